// >>> common/tap_pkg.sv
// Constants and carrier types for the configuration device test access port
package tap_pkg;
  localparam int unsigned IR_LEN     = 10;
  localparam int unsigned BSR_LEN    = 174;
  localparam int unsigned DR32_LEN   = 32;
  localparam int unsigned IO_PINS    = 87;
  // Opcodes; values are arbitrary
  localparam logic [9:0] OP_EXTEST   = 10'h000;
  localparam logic [9:0] OP_SAMPLE   = 10'h055;
  localparam logic [9:0] OP_IDCODE   = 10'h059;
  localparam logic [9:0] OP_USERCODE = 10'h079;
  localparam logic [9:0] OP_RECONFIG = 10'h1E1;
  localparam logic [9:0] OP_HOLDCFG  = 10'h1E2;
  localparam logic [9:0] OP_ISP_EN   = 10'h2CC;
  localparam logic [9:0] OP_ISP_DIS  = 10'h201;
  localparam logic [9:0] OP_BYPASS   = 10'h3FF;
  localparam logic [9:0] IR_CAPTURE  = 10'h001;
  // Idle pin levels {tdi, tms, tck} held by the synchronisers in reset
  localparam logic [2:0] PIN_IDLE    = 3'h6;
  // Identification value is arbitrary; bit 0 stays one
  localparam logic [31:0] IDCODE_VAL = 32'h0A5C_1001;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic tdi;
    logic tms;
    logic tck;
  } jtag_in_t;

  typedef struct packed {
    logic tdo;
    logic tdoOe;
  } jtag_out_t;
endpackage : tap_pkg

// >>> rtl/config_device_jtag_tap.sv
// Test access port with boundary scan, user code and configuration-start control
// How it works
// - Four-pin port, also used for flash programming
// - Instruction register is ten bits long
// - Boundary chain holds 174 cells
// - Sample captures pins, preload loads update latches
// - External test drives pattern, captures input pins
// - Bypass is one stage between TDI and TDO
// - Identification instruction shifts fixed ID out
// - User code shifts a 32-bit programmed pattern
// - Reconfigure holds start line low while current
// - Hold-pending instruction asserts start line before flash
// - Programming instructions follow the 1532 standard
module config_device_jtag_tap (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  // Test port pins
  input  wire tap_pkg::jtag_in_t               jtagIn,
  output tap_pkg::jtag_out_t                   jtagOut,
  // Device pins seen by the boundary chain
  input  wire logic [tap_pkg::IO_PINS-1:0]     pinIn,
  input  wire logic [tap_pkg::IO_PINS-1:0]     coreOut,
  output logic      [tap_pkg::IO_PINS-1:0]     pinOut,
  output logic                                 extestActive,
  // Programmed user code
  input  wire logic [tap_pkg::DR32_LEN-1:0]    userCode,
  // Configuration start line, open drain
  output logic                                 initConfOut,
  output logic                                 initConfOe,
  // Flash programming access
  output logic                                 ispMode,
  output logic                                 flashAccess
);
  // Pin synchronisers
  logic [2:0] syncA_q;
  logic [2:0] syncB_q;
  logic       tckPrev_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_q   <= tap_pkg::PIN_IDLE;
      syncB_q   <= tap_pkg::PIN_IDLE;
      tckPrev_q <= 1'h0;
    end
    else
    begin
      syncA_q   <= {jtagIn.tdi, jtagIn.tms, jtagIn.tck};
      syncB_q   <= syncA_q;
      tckPrev_q <= syncB_q[0];
    end
  end

  wire tdiS  = syncB_q[2];
  wire tmsS  = syncB_q[1];
  wire tckRise = syncB_q[0] & ~tckPrev_q;
  wire tckFall = ~syncB_q[0] & tckPrev_q;

  // Controller state
  tap_pkg::tap_state_t state_q, state_d;
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      tap_pkg::TLR:    state_d = tmsS ? tap_pkg::TLR    : tap_pkg::RTI;
      tap_pkg::RTI:    state_d = tmsS ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: state_d = tmsS ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: state_d = tmsS ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::SH_DR:  state_d = tmsS ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::EX1_DR: state_d = tmsS ? tap_pkg::UPD_DR : tap_pkg::PA_DR;
      tap_pkg::PA_DR:  state_d = tmsS ? tap_pkg::EX2_DR : tap_pkg::PA_DR;
      tap_pkg::EX2_DR: state_d = tmsS ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
      tap_pkg::UPD_DR: state_d = tmsS ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: state_d = tmsS ? tap_pkg::TLR    : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: state_d = tmsS ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::SH_IR:  state_d = tmsS ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::EX1_IR: state_d = tmsS ? tap_pkg::UPD_IR : tap_pkg::PA_IR;
      tap_pkg::PA_IR:  state_d = tmsS ? tap_pkg::EX2_IR : tap_pkg::PA_IR;
      tap_pkg::EX2_IR: state_d = tmsS ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
      tap_pkg::UPD_IR: state_d = tmsS ? tap_pkg::SEL_DR : tap_pkg::RTI;
      default:         state_d = tap_pkg::TLR;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= tap_pkg::TLR;
    else if (tckRise)
      state_q <= state_d;
  end

  // Instruction register
  logic [tap_pkg::IR_LEN-1:0] irShift_q;
  logic [tap_pkg::IR_LEN-1:0] ir_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irShift_q <= tap_pkg::IR_CAPTURE;
      ir_q      <= tap_pkg::OP_IDCODE;
    end
    else if (tckRise)
    begin
      if (state_q == tap_pkg::CAP_IR)
        irShift_q <= tap_pkg::IR_CAPTURE;
      else if (state_q == tap_pkg::SH_IR)
        irShift_q <= {tdiS, irShift_q[tap_pkg::IR_LEN-1:1]};
    end
    else if (tckFall)
    begin
      if (state_q == tap_pkg::TLR)
        ir_q <= tap_pkg::OP_IDCODE;
      else if (state_q == tap_pkg::UPD_IR)
        ir_q <= irShift_q;
    end
  end

  // Decoded states, instructions and strobes
  logic                         inTlr;
  logic                         inCapDr;
  logic                         inShDr;
  logic                         inUpdDr;
  logic                         inShIr;
  logic                         selExtest;
  logic                         selSample;
  logic                         selBsr;
  logic                         selId;
  logic                         selUser;
  logic                         selRcfg;
  logic                         selHold;
  logic                         selIspEn;
  logic                         selIspDis;
  logic                         sel32;
  logic                         selByp;
  logic                         capBsr;
  logic                         shBsr;
  logic                         updBsr;
  logic                         cap32;
  logic                         sh32;
  logic                         capByp;
  logic                         shByp;
  logic                         shifting;
  logic                         tdoNext;
  logic                         holdLine;
  logic                         ispMode_d;
  logic                         flashNext;
  logic [tap_pkg::IO_PINS-1:0]  pinNext;

  assign inTlr   = (state_q == tap_pkg::TLR);
  assign inCapDr = (state_q == tap_pkg::CAP_DR);
  assign inShDr  = (state_q == tap_pkg::SH_DR);
  assign inUpdDr = (state_q == tap_pkg::UPD_DR);
  assign inShIr  = (state_q == tap_pkg::SH_IR);

  // Instruction decode
  function automatic logic isOp(
    input logic [tap_pkg::IR_LEN-1:0] ir,
    input logic [tap_pkg::IR_LEN-1:0] op
  );
    isOp = (ir == op);
  endfunction : isOp

  assign selExtest = isOp(ir_q, tap_pkg::OP_EXTEST);
  assign selSample = isOp(ir_q, tap_pkg::OP_SAMPLE);
  assign selBsr    = selExtest | selSample;
  assign selId     = isOp(ir_q, tap_pkg::OP_IDCODE);
  assign selUser   = isOp(ir_q, tap_pkg::OP_USERCODE);
  assign selRcfg   = isOp(ir_q, tap_pkg::OP_RECONFIG);
  assign selHold   = isOp(ir_q, tap_pkg::OP_HOLDCFG);
  assign selIspEn  = isOp(ir_q, tap_pkg::OP_ISP_EN);
  assign selIspDis = isOp(ir_q, tap_pkg::OP_ISP_DIS);
  assign sel32     = selId | selUser;
  // Unknown opcodes land on the bypass stage
  assign selByp    = ~(selBsr | sel32);

  // Data register strobes
  assign capBsr = tckRise & inCapDr & selBsr;
  assign shBsr  = tckRise & inShDr & selBsr;
  assign updBsr = tckFall & inUpdDr & selBsr;
  assign cap32  = tckRise & inCapDr & sel32;
  assign sh32   = tckRise & inShDr & sel32;
  assign capByp = tckRise & inCapDr & selByp;
  assign shByp  = tckRise & inShDr & selByp;

  // Boundary chain, one shift cell and one update cell per bit
  logic [tap_pkg::BSR_LEN-1:0]  bsr_q;
  logic [tap_pkg::BSR_LEN-1:0]  bsrUpd_q;
  wire  [tap_pkg::BSR_LEN-1:0]  bsrCapture = {pinIn, coreOut};
  wire  [tap_pkg::BSR_LEN-1:0]  bsrShiftIn = {tdiS, bsr_q[tap_pkg::BSR_LEN-1:1]};

  for (genvar c = 0; c < tap_pkg::BSR_LEN; c++)
  begin : g_cell
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        bsr_q[c] <= 1'h0;
      else if (capBsr)
        bsr_q[c] <= bsrCapture[c];
      else if (shBsr)
        bsr_q[c] <= bsrShiftIn[c];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        bsrUpd_q[c] <= 1'h0;
      else if (updBsr)
        bsrUpd_q[c] <= bsr_q[c];
    end
  end : g_cell

  // Identification and user code register
  logic [tap_pkg::DR32_LEN-1:0] dr32_q;
  wire  [tap_pkg::DR32_LEN-1:0] dr32Capture = selId ? tap_pkg::IDCODE_VAL : userCode;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dr32_q <= '0;
    else if (cap32)
      dr32_q <= dr32Capture;
    else if (sh32)
      dr32_q <= {tdiS, dr32_q[tap_pkg::DR32_LEN-1:1]};
  end

  // Bypass stage
  logic                         bypass_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      bypass_q <= 1'h0;
    else if (capByp)
      bypass_q <= 1'h0;
    else if (shByp)
      bypass_q <= tdiS;
  end

  // Serial output mux
  assign shifting = inShDr | inShIr;
  assign tdoNext  = inShIr ? irShift_q[0] :
                    selBsr ? bsr_q[0] : sel32 ? dr32_q[0] : bypass_q;

  // Serial output moves only on falling test clock edges
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      jtagOut <= '0;
    else if (tckFall)
    begin
      jtagOut.tdo   <= tdoNext;
      jtagOut.tdoOe <= shifting;
    end
  end

  // Pins follow the core unless external test drives the update cells
  assign pinNext = selExtest ? bsrUpd_q[tap_pkg::IO_PINS-1:0] : coreOut;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      extestActive <= 1'h0;
    else
      extestActive <= selExtest;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pinOut <= '0;
    else
      pinOut <= pinNext;
  end

  // Configuration-start line, open drain: held low while reconfigure or hold is current
  assign holdLine = selRcfg | selHold;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      initConfOut <= 1'h0;
    else
      initConfOut <= 1'h0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      initConfOe <= 1'h0;
    else
      initConfOe <= holdLine;
  end

  // Programming mode and guarded flash access
  assign ispMode_d = (ispMode | selIspEn) & ~selIspDis & ~inTlr;
  assign flashNext = ispMode_d & initConfOe & selHold;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ispMode <= 1'h0;
    else
      ispMode <= ispMode_d;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flashAccess <= 1'h0;
    else
      flashAccess <= flashNext;
  end
endmodule : config_device_jtag_tap

// >>> dv/config_device_jtag_tap_monitor.sv
// Checker on the test access port outputs
module config_device_jtag_tap_monitor (
  // Watched ports
  input wire logic               clk,
  input wire logic               arst_n,
  input wire tap_pkg::jtag_in_t  jtagIn,
  input wire tap_pkg::jtag_out_t jtagOut,
  input wire logic [86:0]        coreOut,
  input wire logic [86:0]        pinOut,
  input wire logic               extestActive,
  input wire logic               initConfOut,
  input wire logic               initConfOe,
  input wire logic               ispMode,
  input wire logic               flashAccess
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_drain; initConfOut == 1'h0; endproperty
  a_drain: assert property (p_drain) else $error("line high");
  property p_flash; flashAccess |-> initConfOe && ispMode; endproperty
  a_flash: assert property (p_flash) else $error("flash unguarded");
  property p_excl; extestActive |-> !initConfOe; endproperty
  a_excl: assert property (p_excl) else $error("test with line");
  property p_follow;
    $past(arst_n) && !extestActive && !$past(extestActive) |-> pinOut == $past(coreOut);
  endproperty
  a_follow: assert property (p_follow) else $error("pins stale");
  property p_tdo; $changed(jtagOut.tdo) |-> !jtagIn.tck; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo on high");
  property p_oe; $changed(jtagOut.tdoOe) |-> !jtagIn.tck; endproperty
  a_oe: assert property (p_oe) else $error("enable on high");
  property p_isp; $rose(ispMode) |-> !jtagIn.tck; endproperty
  a_isp: assert property (p_isp) else $error("isp off update");
  property p_cfg; $rose(initConfOe) |-> !jtagIn.tck ##1 initConfOe; endproperty
  a_cfg: assert property (p_cfg) else $error("line off update");
endmodule : config_device_jtag_tap_monitor

// >>> dv/jtag_host_model.sv
// Behavioural test host on the four-pin port
module jtag_host_model (
  input  wire logic               clk,
  output tap_pkg::jtag_in_t       jtagIn,
  input  wire tap_pkg::jtag_out_t jtagOut
);
  timeunit 1ns;
  timeprecision 1ns;
  initial jtagIn = 3'h6;
  task automatic pulse(input logic m, input logic d, output logic o);
    jtagIn.tms = m;
    jtagIn.tdi = d;
    repeat (8) @(negedge clk);
    jtagIn.tck = 1'h1;
    o = jtagOut.tdoOe ? jtagOut.tdo : ~jtagOut.tdo;
    repeat (8) @(negedge clk);
    jtagIn.tck = 1'h0;
  endtask : pulse
  task automatic shift(input logic ir, input int n, input logic [173:0] din,
                       output logic [173:0] dout);
    logic o;
    dout = '0;
    pulse(1'h1, 1'h1, o);
    if (ir) pulse(1'h1, 1'h1, o);
    pulse(1'h0, 1'h1, o);
    pulse(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++) pulse(i == n - 1, din[i], dout[i]);
    pulse(1'h1, 1'h1, o);
    pulse(1'h0, 1'h1, o);
  endtask : shift
  task automatic tlr;
    logic o;
    repeat (5) pulse(1'h1, 1'h1, o);
    pulse(1'h0, 1'h1, o);
  endtask : tlr
endmodule : jtag_host_model

// >>> dv/config_device_jtag_tap_tb.sv
// Self-checking bench for the test access port
module config_device_jtag_tap_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [9:0] op; int len; logic [173:0] exp;} row_t;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  tap_pkg::jtag_in_t jtagIn;
  tap_pkg::jtag_out_t jtagOut;
  logic [86:0] pinIn = {3{29'h15A3C96E}};
  logic [86:0] coreOut = {3{29'h0B5E1C27}};
  logic [86:0] pinOut;
  logic [31:0] userCode = 32'hC3A59E01;
  logic [173:0] din = {6{29'h1C7A35E9}};
  logic [173:0] dout;
  logic extestActive, initConfOut, initConfOe, ispMode, flashAccess, confLine;
  int fail_count = 0;
  int check_count = 0;
  row_t rows [5];
  assign confLine = initConfOe ? initConfOut : 1'h1;
  config_device_jtag_tap config_device_jtag_tap_i (.clk(clk), .arst_n(arst_n), .jtagIn(jtagIn),
    .jtagOut(jtagOut), .pinIn(pinIn), .coreOut(coreOut), .pinOut(pinOut),
    .extestActive(extestActive), .userCode(userCode), .initConfOut(initConfOut),
    .initConfOe(initConfOe), .ispMode(ispMode), .flashAccess(flashAccess));
  jtag_host_model jtag_host_model_i (.clk(clk), .jtagIn(jtagIn), .jtagOut(jtagOut));
  initial forever #5 clk = ~clk;
  task automatic chk(input string nm, input logic [173:0] e, input logic [173:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic ir(input logic [9:0] op);
    jtag_host_model_i.shift(1'h1, 20, {154'h0, op, 10'h2B5}, dout);
    chk("ir", {154'h0, 10'h2B5, tap_pkg::IR_CAPTURE}, dout);
  endtask : ir
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial
  begin
    rows[0] = '{tap_pkg::OP_IDCODE, 32, {142'h0, tap_pkg::IDCODE_VAL}};
    rows[1] = '{tap_pkg::OP_USERCODE, 32, {142'h0, userCode}};
    rows[2] = '{tap_pkg::OP_BYPASS, 33, {141'h0, din[31:0], 1'h0}};
    rows[3] = '{10'h3A7, 33, {141'h0, din[31:0], 1'h0}};
    rows[4] = '{tap_pkg::OP_SAMPLE, 174, {pinIn, coreOut}};
    repeat (6) @(negedge clk);
    chk("reset", 174'h0, {168'h0, jtagOut, extestActive, initConfOe, ispMode, flashAccess});
    $display("done reset");
    arst_n = 1'h1;
    repeat (3) @(negedge clk);
    jtag_host_model_i.tlr();
    foreach (rows[k])
    begin
      ir(rows[k].op);
      jtag_host_model_i.shift(1'h0, rows[k].len, din, dout);
      chk("dr", rows[k].exp, dout);
      $display("done row %0d", k);
    end
    ir(tap_pkg::OP_EXTEST);
    chk("drive", {86'h0, 1'h1, din[86:0]}, {86'h0, extestActive, pinOut});
    jtag_host_model_i.shift(1'h0, 174, din, dout);
    chk("grab", {pinIn, 87'h0}, {dout[173:87], 87'h0});
    $display("done extest");
    ir(tap_pkg::OP_RECONFIG);
    chk("line low", 174'h0, {173'h0, confLine});
    ir(tap_pkg::OP_BYPASS);
    chk("line free", 174'h1, {173'h0, confLine});
    ir(tap_pkg::OP_ISP_EN);
    ir(tap_pkg::OP_HOLDCFG);
    chk("hold", 174'h7, {171'h0, initConfOe, ispMode, flashAccess});
    ir(tap_pkg::OP_ISP_DIS);
    chk("unhold", 174'h0, {171'h0, initConfOe, ispMode, flashAccess});
    $display("done start line");
    ir(tap_pkg::OP_ISP_EN);
    jtag_host_model_i.tlr();
    chk("isp off", 174'h0, {173'h0, ispMode});
    jtag_host_model_i.shift(1'h0, 32, din, dout);
    chk("id", {142'h0, tap_pkg::IDCODE_VAL}, dout);
    chk("id lsb", 174'h1, {173'h0, dout[0]});
    $display("done reset state");
    ir(tap_pkg::OP_HOLDCFG);
    chk("held", 174'h0, {173'h0, confLine});
    arst_n = 1'h0;
    repeat (2) @(negedge clk);
    chk("rerun", 174'h0, {168'h0, jtagOut, extestActive, initConfOe, ispMode, flashAccess});
    arst_n = 1'h1;
    repeat (3) @(negedge clk);
    jtag_host_model_i.tlr();
    jtag_host_model_i.shift(1'h0, 32, din, dout);
    chk("id again", {142'h0, tap_pkg::IDCODE_VAL}, dout);
    $display("done mid reset");
    finish_test();
  end
endmodule : config_device_jtag_tap_tb

bind config_device_jtag_tap config_device_jtag_tap_monitor config_device_jtag_tap_monitor_i (
  .clk(clk), .arst_n(arst_n), .jtagIn(jtagIn), .jtagOut(jtagOut), .coreOut(coreOut),
  .pinOut(pinOut), .extestActive(extestActive), .initConfOut(initConfOut),
  .initConfOe(initConfOe), .ispMode(ispMode), .flashAccess(flashAccess));
